// [verilog/tms_mode_ctrl.sv]
// Purpose: Operating mode state machine and status pin signalling of a bus node transceiver.
// Assumes: Pins are synchronous to aclk; analog detectors deliver clean levels.
// Notes:   AXI4-Lite gives status, interrupt and mode readback.
`timescale 1ns/1ps
`include "tms_consts.svh"

module tms_mode_ctrl
  import tms_pkg::*;
#(
  parameter int GTS_CYC  = `TMS_GTS_CYC,
  parameter int UVCC_CYC = `TMS_UVCC_CYC,
  parameter int ACT_CYC  = `TMS_ACT_CYC,
  parameter int IDLE_CYC = `TMS_IDLE_CYC
) (
  // Clock and reset
  input  wire  logic        aclk,
  input  wire  logic        aresetn,
  // Host mode pins
  input  wire  logic        lowpower_sel_n,
  input  wire  logic        mode_select_b,
  // Supply flags and detector events
  input  wire  tms_supply_t supply,
  input  wire  tms_event_t  events,
  input  wire  logic        bus_active_in,
  input  wire  logic        bus_data_in,
  // Status pins; enable is low while driving
  output logic              fault_wake_out,
  output logic              fault_wake_oe_n,
  output logic              rx_activity_n,
  output logic              rx_activity_oe_n,
  output logic              rx_data_out,
  output logic              regulator_switch_out,
  output logic              regulator_switch_oe_n,
  output logic              tx_enable,
  output tms_mode_t         mode,
  output logic              irq,
  // AXI4-Lite slave
  input  wire  logic [7:0]  s_awaddr,
  input  wire  logic        s_awvalid,
  output logic              s_awready,
  input  wire  logic [31:0] s_wdata,
  input  wire  logic [3:0]  s_wstrb,
  input  wire  logic        s_wvalid,
  output logic              s_wready,
  output logic [1:0]        s_bresp,
  output logic              s_bvalid,
  input  wire  logic        s_bready,
  input  wire  logic [7:0]  s_araddr,
  input  wire  logic        s_arvalid,
  output logic              s_arready,
  output logic [31:0]       s_rdata,
  output logic [1:0]        s_rresp,
  output logic              s_rvalid,
  input  wire  logic        s_rready
);

  // ****************************************
  // Pin edges and supply qualifiers
  // ****************************************
  logic        sel_q;
  logic        msb_q;
  logic        sel_rise;
  logic        sel_fall;
  logic        msb_rise;
  logic        msb_fall;
  logic        uv_io_bat;
  logic        core_uv_long;
  logic [31:0] uv_cnt;
  logic [31:0] gts_cnt;
  logic        wake_flag;
  logic        wake_remote;
  logic        err_mode;
  logic        was_lowpower;
  tms_mode_t   next_mode;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_q <= 1'b0;
      msb_q <= 1'b0;
    end else begin
      sel_q <= lowpower_sel_n;
      msb_q <= mode_select_b;
    end
  end

  assign sel_rise  = lowpower_sel_n & ~sel_q;
  assign sel_fall  = ~lowpower_sel_n & sel_q;
  assign msb_rise  = mode_select_b & ~msb_q;
  assign msb_fall  = ~mode_select_b & msb_q;
  assign uv_io_bat = supply.io_supply_low_flag | supply.battery_low_flag;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uv_cnt <= 32'h0;
    end else if (!supply.core_supply_low_flag) begin
      uv_cnt <= 32'h0;
    end else if (uv_cnt <= UVCC_CYC) begin
      uv_cnt <= uv_cnt + 32'h1;
    end
  end
  assign core_uv_long = (uv_cnt > UVCC_CYC);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gts_cnt <= 32'h0;
    end else if (mode != TMS_GOSLEEP || lowpower_sel_n || !mode_select_b) begin
      gts_cnt <= 32'h0;
    end else if (gts_cnt <= GTS_CYC) begin
      gts_cnt <= gts_cnt + 32'h1;
    end
  end

  // ****************************************
  // Mode state machine
  // ****************************************
  always_comb begin
    next_mode = mode;
    unique case (mode)
      TMS_NORMAL: begin
        if (!uv_io_bat && !supply.core_supply_low_flag && !supply.first_power_flag) begin
          if (sel_fall && msb_fall)
            next_mode = TMS_STANDBY;
          else if (sel_fall && mode_select_b)
            next_mode = TMS_GOSLEEP;
          else if (msb_fall && lowpower_sel_n)
            next_mode = TMS_RXONLY;
        end
      end
      TMS_RXONLY: begin
        if (!uv_io_bat && !supply.core_supply_low_flag) begin
          if (sel_fall && msb_rise)
            next_mode = TMS_GOSLEEP;
          else if (sel_fall && !mode_select_b)
            next_mode = TMS_STANDBY;
          else if (msb_rise && lowpower_sel_n)
            next_mode = TMS_NORMAL;
        end
      end
      TMS_STANDBY: begin
        if (!uv_io_bat) begin
          if (sel_rise && msb_rise && !core_uv_long && !supply.core_supply_low_flag)
            next_mode = TMS_NORMAL;
          else if (sel_rise && !mode_select_b && !core_uv_long &&
                   !supply.core_supply_low_flag)
            next_mode = TMS_RXONLY;
          else if (msb_rise && !lowpower_sel_n)
            next_mode = TMS_GOSLEEP;
        end
      end
      TMS_GOSLEEP: begin
        if (!uv_io_bat) begin
          if (sel_rise && mode_select_b && !core_uv_long)
            next_mode = TMS_NORMAL;
          else if (sel_rise && msb_fall && !core_uv_long)
            next_mode = TMS_RXONLY;
          else if (msb_fall && !lowpower_sel_n)
            next_mode = TMS_STANDBY;
          else if (gts_cnt > GTS_CYC)
            next_mode = TMS_SLEEP;
        end
      end
      TMS_SLEEP: begin
        if (sel_rise) begin
          if (uv_io_bat || supply.core_supply_low_flag || core_uv_long)
            next_mode = TMS_STANDBY;
          else if (mode_select_b)
            next_mode = TMS_NORMAL;
          else
            next_mode = TMS_RXONLY;
        end
      end
      TMS_POWOFF: next_mode = TMS_STANDBY;
      default:    next_mode = TMS_STANDBY;
    endcase
    if (supply.power_off)
      next_mode = TMS_POWOFF;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      mode <= TMS_STANDBY;
    else
      mode <= next_mode;
  end

  // ****************************************
  // Wake flag and status source
  // ****************************************
  // Sleep entry clears wake flag; detection in low-power modes sets it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_flag   <= 1'b0;
      wake_remote <= 1'b0;
    end else if (mode == TMS_GOSLEEP && next_mode == TMS_SLEEP) begin
      wake_flag   <= 1'b0;
      wake_remote <= 1'b0;
    end else if ((mode == TMS_STANDBY || mode == TMS_GOSLEEP || mode == TMS_SLEEP) &&
                 (events.wake_local || events.wake_remote) && !wake_flag) begin
      wake_flag   <= 1'b1;
      wake_remote <= events.wake_remote;
    end else if (mode == TMS_NORMAL) begin
      wake_flag   <= 1'b0;
    end
  end

  // Receive-only entry via select rising from low power shows source.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      was_lowpower <= 1'b0;
      err_mode     <= 1'b1;
    end else if (next_mode == TMS_NORMAL) begin
      err_mode <= 1'b1;
    end else if (next_mode == TMS_RXONLY && mode != TMS_RXONLY) begin
      // An entry that also drops mode_select_b came from a host that had it high, so it
      // reports error status rather than the wake-up source.
      err_mode     <= !(sel_rise && !msb_fall && wake_flag && mode != TMS_NORMAL);
      was_lowpower <= wake_remote;
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  always_comb begin
    fault_wake_oe_n       = 1'b0;
    rx_activity_oe_n      = 1'b0;
    regulator_switch_out  = 1'b1;
    regulator_switch_oe_n = 1'b0;
    tx_enable             = (mode == TMS_NORMAL);
    if (!lowpower_sel_n)
      fault_wake_out = !wake_flag;
    else if (mode_select_b || err_mode)
      fault_wake_out = !events.error_det;
    else
      fault_wake_out = !was_lowpower;
    if (mode == TMS_POWOFF)
      fault_wake_oe_n = 1'b1;
    if (mode == TMS_SLEEP)
      regulator_switch_oe_n = 1'b1;
    if (mode == TMS_POWOFF)
      rx_activity_oe_n = 1'b1;
  end

  // ****************************************
  // Receive pins
  // ****************************************
  logic [31:0] act_cnt;
  logic        bus_seen;

  // persistence filter on activity and idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_cnt  <= 32'h0;
      bus_seen <= 1'b0;
    end else if (bus_active_in == bus_seen) begin
      act_cnt <= 32'h0;
    end else if (act_cnt + 32'h1 >= (bus_seen ? IDLE_CYC : ACT_CYC)) begin
      act_cnt  <= 32'h0;
      bus_seen <= bus_active_in;
    end else begin
      act_cnt <= act_cnt + 32'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_activity_n <= 1'b1;
      rx_data_out   <= 1'b1;
    end else if (mode == TMS_NORMAL || mode == TMS_RXONLY) begin
      rx_activity_n <= !bus_seen;
      rx_data_out   <= bus_seen ? bus_data_in : 1'b1;
    end else if (mode == TMS_POWOFF) begin
      rx_activity_n <= 1'b1;
      rx_data_out   <= 1'b1;
    end else begin
      rx_activity_n <= !wake_flag;
      rx_data_out   <= !wake_flag;
    end
  end

  // ****************************************
  // Interrupts and AXI4-Lite slave
  // ****************************************
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [2:0] irq_set;
  logic       aw_hold;
  logic       w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic       wr_go;

  assign irq_set = {events.error_det, next_mode != mode, wake_flag};
  assign irq     = |(irq_stat & irq_mask);
  assign s_awready = !aw_hold && !s_bvalid;
  assign s_wready  = !w_hold && !s_bvalid;
  assign s_arready = !s_rvalid;
  assign wr_go     = aw_hold && w_hold && !s_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      s_bvalid <= 1'b0;
      s_bresp  <= `TMS_RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_hold <= 1'b1;
        w_data <= s_wdata & {{8{s_wstrb[3]}}, {8{s_wstrb[2]}}, {8{s_wstrb[1]}}, {8{s_wstrb[0]}}};
      end
      if (wr_go) begin
        aw_hold  <= 1'b0;
        w_hold   <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= (aw_addr == `TMS_ADDR_STAT || aw_addr == `TMS_ADDR_MASK) ?
                    `TMS_RESP_OKAY : `TMS_RESP_SLV;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // Set wins over write-one-to-clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
    end else begin
      if (wr_go && aw_addr == `TMS_ADDR_MASK)
        irq_mask <= w_data[2:0];
      irq_stat <= (irq_stat & ~((wr_go && aw_addr == `TMS_ADDR_STAT) ? w_data[2:0] : 3'h0))
                  | irq_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0;
      s_rresp  <= `TMS_RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rresp  <= `TMS_RESP_OKAY;
      unique case (s_araddr)
        `TMS_ADDR_STAT: s_rdata <= {29'h0, irq_stat};
        `TMS_ADDR_MASK: s_rdata <= {29'h0, irq_mask};
        `TMS_ADDR_MODE: s_rdata <= {26'h0, mode};
        `TMS_ADDR_CTRL: s_rdata <= {29'h0, wake_remote, wake_flag, err_mode};
        default: begin
          s_rdata <= 32'h0;
          s_rresp <= `TMS_RESP_SLV;
        end
      endcase
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_poweroff_float: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == TMS_POWOFF |-> fault_wake_oe_n) else $error("status pin driven in PowerOff");
  chk_tx_normal: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_enable == (mode == TMS_NORMAL)) else $error("transmitter enable wrong");
  chk_reg_sleep: assert property (@(posedge aclk) disable iff (!aresetn)
    regulator_switch_oe_n == (mode == TMS_SLEEP)) else $error("regulator drive wrong");
  chk_wake_status: assert property (@(posedge aclk) disable iff (!aresetn)
    !lowpower_sel_n |-> fault_wake_out == !wake_flag) else $error("wake status wrong");
  chk_normal_err: assert property (@(posedge aclk) disable iff (!aresetn)
    lowpower_sel_n && mode_select_b |-> fault_wake_out == !events.error_det)
    else $error("error status wrong");
  chk_sleep_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == TMS_GOSLEEP && !supply.power_off ##1 mode == TMS_SLEEP |-> !wake_flag)
    else $error("wake flag kept on Sleep entry");
  chk_uv_block: assert property (@(posedge aclk) disable iff (!aresetn)
    core_uv_long && mode != TMS_NORMAL |=> mode != TMS_NORMAL)
    else $error("Normal entered under core undervoltage");
  chk_norm_rx: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == TMS_NORMAL && lowpower_sel_n && $past(lowpower_sel_n) && msb_fall && !uv_io_bat
    && !supply.core_supply_low_flag && !supply.first_power_flag && !supply.power_off
    |=> mode == TMS_RXONLY) else $error("Normal to Receive-only missed");

endmodule : tms_mode_ctrl

// [verilog/tms_consts.svh]
// Purpose: Constants for the transceiver mode and status block.
// Assumes: 25 MHz clock.
// Notes:   Times in ns, cycle counts derived from them.
`ifndef TMS_CONSTS_SVH
`define TMS_CONSTS_SVH
`define TMS_CLK_PERIOD_NS   40
`define TMS_T_GOTOSLEEP_NS  20000
`define TMS_T_ACT_NS        200
`define TMS_T_IDLE_NS       200
`define TMS_T_UVCC_NS       100000
`define TMS_GTS_CYC  ((`TMS_T_GOTOSLEEP_NS + `TMS_CLK_PERIOD_NS - 1) / `TMS_CLK_PERIOD_NS)
`define TMS_ACT_CYC  ((`TMS_T_ACT_NS + `TMS_CLK_PERIOD_NS - 1) / `TMS_CLK_PERIOD_NS)
`define TMS_IDLE_CYC ((`TMS_T_IDLE_NS + `TMS_CLK_PERIOD_NS - 1) / `TMS_CLK_PERIOD_NS)
`define TMS_UVCC_CYC ((`TMS_T_UVCC_NS + `TMS_CLK_PERIOD_NS - 1) / `TMS_CLK_PERIOD_NS)
`define TMS_IRQ_WAKE   0
`define TMS_IRQ_MODE   1
`define TMS_IRQ_ERR    2
`define TMS_ADDR_STAT  8'h00
`define TMS_ADDR_MASK  8'h04
`define TMS_ADDR_MODE  8'h08
`define TMS_ADDR_CTRL  8'h0c
`define TMS_RESP_OKAY  2'h0
`define TMS_RESP_SLV   2'h2
`endif

// [verilog/tms_pkg.sv]
// Purpose: Types for the transceiver mode and status block.
// Assumes: Used with tms_consts.svh.
// Notes:   Mode codes are one-hot.
package tms_pkg;
  typedef enum logic [5:0] {
    TMS_NORMAL  = 6'h01,
    TMS_RXONLY  = 6'h02,
    TMS_GOSLEEP = 6'h04,
    TMS_STANDBY = 6'h08,
    TMS_SLEEP   = 6'h10,
    TMS_POWOFF  = 6'h20
  } tms_mode_t;

  typedef struct packed {
    logic core_supply_low_flag;
    logic io_supply_low_flag;
    logic battery_low_flag;
    logic first_power_flag;
    logic power_off;
  } tms_supply_t;

  typedef struct packed {
    logic wake_local;
    logic wake_remote;
    logic error_det;
  } tms_event_t;
endpackage : tms_pkg

// [sim/tms_host_model.sv]
// Purpose: Host controller model that drives the mode pins and reads the status pin.
// Assumes: The bench requests pin levels; they reach the pins at the next rising edge.
// Notes:   A released status pin reads as a level that toggles every cycle.
`timescale 1ns/1ps

module tms_host_model (
  // Clock
  input  wire logic aclk,
  // Requested pin levels
  input  wire logic want_lp,
  input  wire logic want_ms,
  // Device pins
  input  wire logic fault_wake_out,
  input  wire logic fault_wake_oe_n,
  output logic      lowpower_sel_n,
  output logic      mode_select_b,
  output logic      status_seen
);
  logic toggle;

  initial begin
    lowpower_sel_n = 1'b0;
    mode_select_b  = 1'b0;
    toggle         = 1'b0;
  end

  // Pins move only on an edge, as a clocked host would drive them.
  always @(posedge aclk) begin
    lowpower_sel_n <= want_lp;
    mode_select_b  <= want_ms;
    toggle         <= ~toggle;
  end

  assign status_seen = fault_wake_oe_n ? toggle : fault_wake_out;
endmodule : tms_host_model

// [sim/tms_mode_ctrl_test.sv]
// Purpose: Self-checking bench for the mode and status block.
// Assumes: Short counts are set by parameters; host pins come from the host model.
// Notes:   Registers are reached through a small AXI4-Lite master.
`timescale 1ns/1ps
`include "tms_consts.svh"

module tms_mode_ctrl_test
  import tms_pkg::*;
;
  localparam int GTS = 8;
  localparam int UVC = 4;
  localparam int ACT = 4;
  localparam int IDL = 4;

  logic        aclk, aresetn, want_lp, want_ms, lowpower_sel_n, mode_select_b, status_seen;
  tms_supply_t sup;
  tms_event_t  ev;
  tms_mode_t   mode;
  logic        bus_active_in, bus_data_in, fault_wake_out, fault_wake_oe_n, irq;
  logic        rx_activity_n, rx_activity_oe_n, rx_data_out, tx_enable;
  logic        regulator_switch_out, regulator_switch_oe_n;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp, resp;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  int          failures, checked, i;
  logic [1:0]  pins [9] = '{2'b10, 2'b11, 2'b00, 2'b10, 2'b01, 2'b11, 2'b01, 2'b10, 2'b00};
  tms_mode_t   dest [9] = '{TMS_RXONLY, TMS_NORMAL, TMS_STANDBY, TMS_RXONLY, TMS_GOSLEEP,
                            TMS_NORMAL, TMS_GOSLEEP, TMS_RXONLY, TMS_STANDBY};

  always #20 aclk = ~aclk;

  tms_mode_ctrl #(.GTS_CYC(GTS), .UVCC_CYC(UVC), .ACT_CYC(ACT), .IDLE_CYC(IDL)) DUT (
    .aclk(aclk), .aresetn(aresetn), .lowpower_sel_n(lowpower_sel_n),
    .mode_select_b(mode_select_b), .supply(sup), .events(ev),
    .bus_active_in(bus_active_in), .bus_data_in(bus_data_in),
    .fault_wake_out(fault_wake_out), .fault_wake_oe_n(fault_wake_oe_n),
    .rx_activity_n(rx_activity_n), .rx_activity_oe_n(rx_activity_oe_n),
    .rx_data_out(rx_data_out), .regulator_switch_out(regulator_switch_out),
    .regulator_switch_oe_n(regulator_switch_oe_n), .tx_enable(tx_enable), .mode(mode),
    .irq(irq), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready));

  tms_host_model host (
    .aclk(aclk), .want_lp(want_lp), .want_ms(want_ms), .fault_wake_out(fault_wake_out),
    .fault_wake_oe_n(fault_wake_oe_n), .lowpower_sel_n(lowpower_sel_n),
    .mode_select_b(mode_select_b), .status_seen(status_seen));

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic timed_out();
    failures++;
    $display("ERROR at %0t ns: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
    print_verdict();
  endtask : timed_out

  task automatic step(input int n);
    repeat (n) @(posedge aclk);
  endtask : step

  // Requests new pin levels and waits a bounded time for the expected mode.
  task automatic go(input logic lp, input logic ms, input tms_mode_t exp);
    int n;
    want_lp <= lp;
    want_ms <= ms;
    for (n = 0; n < 12 && mode !== exp; n++) @(posedge aclk);
    chk(32'(mode), 32'(exp));
  endtask : go

  // ****************************************
  // AXI4-Lite master
  // ****************************************
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge aclk);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_bvalid === 1'b1 && aw_ok && w_ok) begin
        resp = s_bresp;
        s_bready <= 1'b0;
        break;
      end
      if (s_awready === 1'b1 && !aw_ok) begin
        aw_ok = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (s_wready === 1'b1 && !w_ok) begin
        w_ok = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    if (n == 40) timed_out();
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_arready === 1'b1) s_arvalid <= 1'b0;
      if (s_rvalid === 1'b1) begin
        rd   = s_rdata;
        resp = s_rresp;
        s_rready <= 1'b0;
        break;
      end
    end
    if (n == 40) timed_out();
  endtask : axi_rd

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {aclk, aresetn, want_lp, want_ms, bus_active_in, s_awvalid, s_wvalid} = '0;
    {s_bready, s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata} = '0;
    {sup, ev, failures, checked} = '0;
    bus_data_in = 1'b1;
    s_wstrb     = 4'hf;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    step(2);
    chk(32'(mode), 32'(TMS_STANDBY));
    chk(32'({rx_activity_n, rx_data_out, fault_wake_out}), 32'h7);
    sup.core_supply_low_flag <= 1'b1;
    step(UVC + 4);
    want_lp <= 1'b1;
    want_ms <= 1'b1;
    step(8);
    chk(32'(mode), 32'(TMS_STANDBY));
    want_lp <= 1'b0;
    want_ms <= 1'b0;
    step(4);
    go(1'b0, 1'b1, TMS_GOSLEEP);
    sup.core_supply_low_flag <= 1'b0;
    go(1'b0, 1'b0, TMS_STANDBY);
    go(1'b1, 1'b1, TMS_NORMAL);
    chk(32'({tx_enable, regulator_switch_out, regulator_switch_oe_n}), 32'h6);
    chk(32'(fault_wake_out), 32'h1);
    ev.error_det <= 1'b1;
    step(2);
    chk(32'(fault_wake_out), 32'h0);
    ev.error_det  <= 1'b0;
    bus_active_in <= 1'b1;
    step(2);
    bus_active_in <= 1'b0;
    step(3);
    chk(32'(rx_activity_n), 32'h1);
    bus_active_in <= 1'b1;
    bus_data_in   <= 1'b0;
    step(ACT + 3);
    chk(32'({rx_activity_n, rx_data_out}), 32'h0);
    bus_data_in <= 1'b1;
    step(3);
    chk(32'(rx_data_out), 32'h1);
    bus_active_in <= 1'b0;
    step(IDL + 3);
    chk(32'({rx_activity_n, rx_data_out}), 32'h3);
    for (i = 0; i < 9; i++) begin
      go(pins[i][1], pins[i][0], dest[i]);
      chk(32'(tx_enable), 32'(dest[i] == TMS_NORMAL));
    end
    go(1'b0, 1'b1, TMS_GOSLEEP);
    step(GTS + 4);
    chk(32'(mode), 32'(TMS_SLEEP));
    chk(32'({regulator_switch_oe_n, fault_wake_out, rx_activity_n, rx_data_out}), 32'hf);
    want_ms <= 1'b0;
    ev.wake_remote <= 1'b1;
    step(1);
    ev.wake_remote <= 1'b0;
    step(3);
    chk(32'({fault_wake_out, rx_activity_n, rx_data_out}), 32'h0);
    go(1'b1, 1'b0, TMS_RXONLY);
    chk(32'(status_seen), 32'h0);
    go(1'b1, 1'b1, TMS_NORMAL);
    go(1'b1, 1'b0, TMS_RXONLY);
    chk(32'(status_seen), 32'h1);
    ev.error_det <= 1'b1;
    step(2);
    chk(32'(status_seen), 32'h0);
    ev.error_det <= 1'b0;
    axi_rd(`TMS_ADDR_MODE);
    chk(rd, 32'(TMS_RXONLY));
    chk(32'(irq), 32'h0);
    axi_wr(`TMS_ADDR_MASK, 32'h1 << `TMS_IRQ_MODE);
    step(2);
    chk(32'(irq), 32'h1);
    axi_wr(`TMS_ADDR_STAT, 32'h1 << `TMS_IRQ_MODE);
    step(2);
    chk(32'(irq), 32'h0);
    axi_rd(`TMS_ADDR_MASK);
    chk(rd, 32'h1 << `TMS_IRQ_MODE);
    axi_rd(8'h10);
    chk(32'(resp), 32'(`TMS_RESP_SLV));
    axi_wr(8'h10, 32'h0);
    chk(32'(resp), 32'(`TMS_RESP_SLV));
    go(1'b1, 1'b1, TMS_NORMAL);
    step(2);
    chk(32'(irq), 32'h1);
    axi_wr(`TMS_ADDR_MASK, 32'h0);
    step(2);
    chk(32'(irq), 32'h0);
    sup.power_off <= 1'b1;
    step(4);
    chk(32'(mode), 32'(TMS_POWOFF));
    chk(32'({fault_wake_oe_n, rx_activity_oe_n, rx_data_out}), 32'h7);
    print_verdict();
  end
endmodule : tms_mode_ctrl_test
